// file: hdl/pbf_fifo_pair.sv
// receive and transmit byte fifos with spi access, thresholds and output pin select
`timescale 1ns/10ps
module pbf_fifo_pair
  import pbf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                               clk,
  input  wire logic                               resetn,
  input  wire logic                               link_clk,
  input  wire logic                               spi_sclk,
  input  wire logic                               spi_csn,
  input  wire logic                               spi_mosi,
  output logic                                    spi_miso,
  output logic                                    spi_miso_oe_n,
  input  wire logic                               sleep_req,
  input  wire logic         [2:0]                 radio_state,
  input  wire logic         [3:0]                 fill_threshold_select,
  input  wire pbf_gpo_src_t [GPO_PINS-1:0]        output_pin_source_select,
  input  wire pbf_byte_t                          demod_in,
  output logic                                    rx_wr_ready,
  input  wire logic                               mod_req,
  output pbf_byte_t                               mod_out,
  output logic              [CNT_W-1:0]           rx_fill_count,
  output logic              [CNT_W-1:0]           tx_fill_count,
  output logic                                    rx_overflow,
  output logic                                    tx_underflow,
  output logic              [GPO_PINS-1:0]        general_output_pin
);
  // clk side: pin and link flag synchronisers, sclk/csn/mosi/rx_ovf/tx_udf
  logic [4:0]       sy_s1_q, sy_s2_q;
  logic             sclk_s, csn_s, mosi_s;
  logic             sclk_prev_q, rise, fall;
  // link side: reset release and sleep crossing
  logic             lrst_s1_q, lrst_n_q, slp_s1_q, slp_s2_q;
  logic             mod_valid_q, mod_valid_d;
  logic [7:0]       mod_data_q, mod_data_d;
  // spi engine
  pbf_spi_st_t      st_q, st_d;
  logic [2:0]       bit_q, bit_d;
  logic [7:0]       sh_in_q, sh_in_d, byte_out_q, byte_out_d, in_byte, read_val;
  pbf_hdr_t         hdr_q, hdr_d;
  logic             miso_q, miso_d, load_q, load_d, rx_pop, tx_push;
  // fifo sides
  logic [CNT_W-1:0] rx_cnt, tx_cnt;
  logic [7:0]       rx_r_data, tx_r_data;
  logic             rx_r_valid, tx_w_ready, rx_ovf_l, tx_udf_l;
  // threshold and pins
  logic             rx_thr_q, rx_thr_d, tx_thr_q, tx_thr_d;
  logic [GPO_PINS-1:0] gpo_q, gpo_d;

  assign sclk_s = sy_s2_q[0];
  assign csn_s  = sy_s2_q[1];
  assign mosi_s = sy_s2_q[2];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sy_s1_q     <= 5'h02;
      sy_s2_q     <= 5'h02;
      sclk_prev_q <= 1'b0;
    end else begin
      sy_s1_q     <= {tx_udf_l, rx_ovf_l, spi_mosi, spi_csn, spi_sclk};
      sy_s2_q     <= sy_s1_q;
      sclk_prev_q <= sclk_s;
    end
  end

  // link reset releases on link_clk so the link side leaves reset cleanly
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lrst_s1_q <= 1'b0;
      lrst_n_q  <= 1'b0;
      slp_s1_q  <= 1'b0;
      slp_s2_q  <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n_q  <= lrst_s1_q;
      slp_s1_q  <= sleep_req;
      slp_s2_q  <= slp_s1_q;
    end
  end

  // receive buffer: demodulator writes on link_clk, host reads on clk
  pbf_async_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
    .wclk    (link_clk),
    .wrst_n  (lrst_n_q),
    .wflush  (slp_s2_q),
    .w_valid (demod_in.valid),
    .w_data  (demod_in.data),
    .w_ready (rx_wr_ready),
    .w_count (),
    .w_ovf   (rx_ovf_l),
    .rclk    (clk),
    .rrst_n  (resetn),
    .rflush  (sleep_req),
    .r_ready (rx_pop),
    .r_data  (rx_r_data),
    .r_valid (rx_r_valid),
    .r_count (rx_cnt),
    .r_udf   ()
  );

  // transmit buffer: host writes on clk, modulator reads on link_clk
  pbf_async_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .wclk    (clk),
    .wrst_n  (resetn),
    .wflush  (sleep_req),
    .w_valid (tx_push),
    .w_data  (in_byte),
    .w_ready (tx_w_ready),
    .w_count (tx_cnt),
    .w_ovf   (),
    .rclk    (link_clk),
    .rrst_n  (lrst_n_q),
    .rflush  (slp_s2_q),
    .r_ready (mod_req),
    .r_data  (tx_r_data),
    .r_valid (),
    .r_count (),
    .r_udf   (tx_udf_l)
  );

  // the modulator sees data one link cycle after its request; the head word is
  // caught at the request because the store moves on to the next word at once
  always_comb begin
    mod_valid_d = mod_req & ~slp_s2_q;
    mod_data_d  = mod_req ? tx_r_data : mod_data_q;
  end

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      mod_valid_q <= 1'b0;
      mod_data_q  <= BYTE_RST;
    end else begin
      mod_valid_q <= mod_valid_d;
      mod_data_q  <= mod_data_d;
    end
  end

  assign mod_out = '{valid: mod_valid_q, data: mod_data_q};

  // spi slave, mode 0; sclk must stay well below a quarter of clk
  always_comb begin
    rise     = sclk_s & ~sclk_prev_q;
    fall     = ~sclk_s & sclk_prev_q;
    in_byte  = {sh_in_q[6:0], mosi_s};
    case (hdr_q.addr)
      ADDR_FIFO:    read_val = hdr_q.rw ? rx_r_data : pbf_status_t'{RDY_N_VAL, radio_state, sat4(tx_cnt)};
      ADDR_RXBYTES: read_val = {rx_overflow, rx_cnt};
      ADDR_TXBYTES: read_val = {tx_underflow, tx_cnt};
      default:      read_val = BYTE_RST;
    endcase
    st_d       = st_q;
    bit_d      = bit_q;
    sh_in_d    = sh_in_q;
    byte_out_d = byte_out_q;
    hdr_d      = hdr_q;
    miso_d     = miso_q;
    load_d     = 1'b0;
    rx_pop     = 1'b0;
    tx_push    = 1'b0;
    if (csn_s) begin
      st_d  = SPI_IDLE;
      bit_d = '0;
    end else begin
      case (st_q)
        SPI_IDLE: begin
          st_d       = SPI_HDR;
          bit_d      = '0;
          byte_out_d = pbf_status_t'{RDY_N_VAL, radio_state, 4'h0};
          miso_d     = RDY_N_VAL;
        end
        SPI_HDR: begin
          if (rise) begin
            sh_in_d = in_byte;
            bit_d   = bit_q + 3'h1;
            if (bit_q == '0) begin
              byte_out_d[3:0] = mosi_s ? sat4(rx_cnt) : sat4(tx_cnt);
            end
            if (bit_q == BIT_LAST) begin
              hdr_d = pbf_hdr_t'(in_byte);
              st_d  = SPI_DATA;
            end
          end
          if (fall) begin
            miso_d = byte_out_q[BIT_LAST - bit_q];
          end
        end
        SPI_DATA: begin
          if (rise) begin
            sh_in_d = in_byte;
            bit_d   = bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
              // a write into a full buffer is dropped rather than corrupting it
              tx_push = ~hdr_q.rw & (hdr_q.addr == ADDR_FIFO) & tx_w_ready;
              // pop only once the whole byte is out, so a burst cut by csn keeps its next byte
              rx_pop  = hdr_q.rw & (hdr_q.addr == ADDR_FIFO) & rx_r_valid;
              if (!hdr_q.burst) begin
                st_d       = SPI_HDR;
                byte_out_d = pbf_status_t'{RDY_N_VAL, radio_state, 4'h0};
              end
            end
          end
          if (fall) begin
            if (bit_q == '0) begin
              load_d = 1'b1;
            end else begin
              miso_d = byte_out_q[BIT_LAST - bit_q];
            end
          end
          if (load_q) begin
            byte_out_d = read_val;
            miso_d     = read_val[7];
          end
        end
        default: st_d = SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q          <= SPI_IDLE;
      bit_q         <= '0;
      sh_in_q       <= BYTE_RST;
      byte_out_q    <= BYTE_RST;
      hdr_q         <= '0;
      miso_q        <= 1'b0;
      load_q        <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      st_q          <= st_d;
      bit_q         <= bit_d;
      sh_in_q       <= sh_in_d;
      byte_out_q    <= byte_out_d;
      hdr_q         <= hdr_d;
      miso_q        <= miso_d;
      load_q        <= load_d;
      spi_miso_oe_n <= csn_s;
    end
  end

  assign spi_miso      = miso_q;
  assign rx_fill_count = rx_cnt;
  assign tx_fill_count = tx_cnt;
  assign rx_overflow   = sy_s2_q[3];
  assign tx_underflow  = sy_s2_q[4];

  // one code drives both thresholds; compare is live so the flag also falls at once
  always_comb begin
    rx_thr_d = rx_cnt >= rx_thr_of(fill_threshold_select);
    tx_thr_d = tx_cnt >= tx_thr_of(fill_threshold_select);
    for (int i = 0; i < GPO_PINS; i++) begin
      gpo_d[i] = gpo_pick(output_pin_source_select[i], rx_thr_d, tx_thr_d, rx_r_valid, ~tx_w_ready);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_thr_q <= 1'b0;
      tx_thr_q <= 1'b0;
      gpo_q    <= '0;
    end else begin
      rx_thr_q <= rx_thr_d;
      tx_thr_q <= tx_thr_d;
      gpo_q    <= gpo_d;
    end
  end

  assign general_output_pin = gpo_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_tx_push_room: assert property (tx_push |-> tx_w_ready && !hdr_q.rw)
    else $error("transmit push without room");
  a_rx_pop_load: assert property (rx_pop |-> rx_r_valid && rise && bit_q == BIT_LAST)
    else $error("receive pop outside a completed byte");
  a_rx_head_load: assert property ((load_q && !csn_s && st_q == SPI_DATA && hdr_q.rw &&
    hdr_q.addr == ADDR_FIFO) |=> byte_out_q == $past(rx_r_data))
    else $error("read byte not taken from buffer head");
  a_hdr_fill: assert property ((st_q == SPI_HDR && !csn_s && rise && bit_q == 3'h0) |=>
    byte_out_q[3:0] == ($past(mosi_s) ? sat4($past(rx_cnt)) : sat4($past(tx_cnt))))
    else $error("header status fill wrong");
  a_rx_thr_level: assert property (1'b1 |=>
    rx_thr_q == ($past(rx_cnt) >= rx_thr_of($past(fill_threshold_select))))
    else $error("receive threshold flag wrong");
  a_tx_thr_drop: assert property ((tx_cnt < tx_thr_of(fill_threshold_select)) |=> !tx_thr_q)
    else $error("transmit threshold flag held below level");
  a_sleep_flush: assert property (sleep_req [*3] |-> rx_cnt == '0 && tx_cnt == '0 && !rx_r_valid)
    else $error("buffers not emptied in sleep");
  a_gpo_route: assert property ((output_pin_source_select[0] == SRC_RX_THR) |=>
    general_output_pin[0] == rx_thr_q)
    else $error("output pin not following threshold");

  c_burst_read: cover property (rx_pop ##[1:400] rx_pop);
  c_rx_thr_rise: cover property ($rose(rx_thr_q));
  c_tx_thr_fall: cover property ($fell(tx_thr_q));
  c_underflow: cover property ($rose(tx_underflow));
endmodule

// file: common/pbf_pkg.sv
// shared constants, carriers and decode functions for the packet byte fifo pair
package pbf_pkg;
  localparam int          FIFO_DEPTH    = 64;
  localparam int          FIFO_AW       = 6;
  localparam int          CNT_W         = 7;
  localparam int          GPO_PINS      = 3;
  localparam logic [5:0]  ADDR_FIFO     = 6'h3F;
  localparam logic [5:0]  ADDR_RXBYTES  = 6'h3A;
  localparam logic [5:0]  ADDR_TXBYTES  = 6'h3B;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [6:0]  RX_THR_STEP   = 7'h04;
  localparam logic [6:0]  TX_THR_BASE   = 7'h3D;
  localparam logic [3:0]  NIBBLE_MAX    = 4'hF;
  localparam logic        RDY_N_VAL     = 1'b0;

  typedef struct packed {
    logic       rw;
    logic       burst;
    logic [5:0] addr;
  } pbf_hdr_t;

  typedef struct packed {
    logic       rdy_n;
    logic [2:0] state;
    logic [3:0] fill;
  } pbf_status_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pbf_byte_t;

  typedef enum logic [1:0] {SRC_RX_THR, SRC_TX_THR, SRC_RX_AVAIL, SRC_TX_FULL} pbf_gpo_src_t;
  typedef enum logic [1:0] {SPI_IDLE, SPI_HDR, SPI_DATA} pbf_spi_st_t;

  // receive threshold is 4*(v+1)
  function automatic logic [CNT_W-1:0] rx_thr_of(input logic [3:0] v);
    return CNT_W'({v, 2'b00}) + RX_THR_STEP;
  endfunction

  // transmit threshold is 61-4*v, counting the other way
  function automatic logic [CNT_W-1:0] tx_thr_of(input logic [3:0] v);
    return TX_THR_BASE - CNT_W'({v, 2'b00});
  endfunction

  function automatic logic [3:0] sat4(input logic [CNT_W-1:0] c);
    return (c > CNT_W'(NIBBLE_MAX)) ? NIBBLE_MAX : c[3:0];
  endfunction

  function automatic logic gpo_pick(input pbf_gpo_src_t s, input logic rxt, input logic txt,
                                    input logic rxa, input logic txf);
    case (s)
      SRC_RX_THR:   return rxt;
      SRC_TX_THR:   return txt;
      SRC_RX_AVAIL: return rxa;
      default:      return txf;
    endcase
  endfunction
endpackage

// file: hdl/pbf_dp_mem.sv
// dual clock byte store with registered read data
`timescale 1ns/10ps
module pbf_dp_mem
  import pbf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW    = FIFO_AW
) (
  input  wire logic             wclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             rclk,
  input  wire logic             rrst_n,
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_d;

  always_ff @(posedge wclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_comb begin
    rdata_d = re ? mem_q[raddr] : rdata_q;
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end
endmodule

// file: hdl/pbf_async_fifo.sv
// two clock fifo with gray pointers, fill counts and sticky error flags
`timescale 1ns/10ps
module pbf_async_fifo
  import pbf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             wclk,
  input  wire logic             wrst_n,
  input  wire logic             wflush,
  input  wire logic             w_valid,
  input  wire logic [WIDTH-1:0] w_data,
  output logic                  w_ready,
  output logic      [AW:0]      w_count,
  output logic                  w_ovf,
  input  wire logic             rclk,
  input  wire logic             rrst_n,
  input  wire logic             rflush,
  input  wire logic             r_ready,
  output logic      [WIDTH-1:0] r_data,
  output logic                  r_valid,
  output logic      [AW:0]      r_count,
  output logic                  r_udf
);
  // depth must be a power of two for the gray pointers to wrap cleanly
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = g;
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic [AW:0] wbin_q, wbin_d, wgray_q, rg_s1_q, rg_s2_q, wcnt_d;
  logic [AW:0] rbin_q, rbin_d, rgray_q, wg_s1_q, wg_s2_q, rcnt_d;
  logic        push, pop, wready_d, ovf_d, rvalid_d, udf_d;

  always_comb begin
    push     = w_valid & w_ready & ~wflush;
    wbin_d   = wflush ? '0 : wbin_q + (AW+1)'(push);
    wcnt_d   = wflush ? '0 : wbin_d - g2b(rg_s2_q);
    wready_d = ~wflush & (wcnt_d != FULL_CNT);
    ovf_d    = (w_valid & ~w_ready & ~wflush) | (w_ovf & ~wflush);
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg_s1_q <= '0;
      rg_s2_q <= '0;
      w_count <= '0;
      w_ready <= 1'b0;
      w_ovf   <= 1'b0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= wbin_d ^ (wbin_d >> 1);
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
      w_count <= wcnt_d;
      w_ready <= wready_d;
      w_ovf   <= ovf_d;
    end
  end

  always_comb begin
    pop      = r_ready & r_valid & ~rflush;
    rbin_d   = rflush ? '0 : rbin_q + (AW+1)'(pop);
    rcnt_d   = rflush ? '0 : g2b(wg_s2_q) - rbin_d;
    rvalid_d = ~rflush & (rcnt_d != '0);
    udf_d    = (r_ready & ~r_valid & ~rflush) | (r_udf & ~rflush);
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
      r_count <= '0;
      r_valid <= 1'b0;
      r_udf   <= 1'b0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= rbin_d ^ (rbin_d >> 1);
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
      r_count <= rcnt_d;
      r_valid <= rvalid_d;
      r_udf   <= udf_d;
    end
  end

  // read data shows the oldest word whenever one is held, so a reader can look before it pops
  pbf_dp_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .wclk    (wclk),
    .we      (push),
    .waddr   (wbin_q[AW-1:0]),
    .wdata   (w_data),
    .rclk    (rclk),
    .rrst_n  (rrst_n),
    .re      (rvalid_d),
    .raddr   (rbin_d[AW-1:0]),
    .rdata_q (r_data)
  );

  a_ovf_sticky: assert property (@(posedge wclk) disable iff (!wrst_n)
    (w_valid && !w_ready && !wflush) |=> w_ovf ##1 (w_ovf || $past(wflush)))
    else $error("overflow flag not raised and held");
  a_udf_sticky: assert property (@(posedge rclk) disable iff (!rrst_n)
    (r_ready && !r_valid && !rflush) |=> r_udf)
    else $error("underflow flag not raised");
  a_depth_bound: assert property (@(posedge wclk) disable iff (!wrst_n)
    (w_count <= FULL_CNT) && (!w_ready || w_count < FULL_CNT))
    else $error("fill count beyond depth");
endmodule

// file: test/pbf_spi_host.sv
// spi master model of the host microcontroller
`timescale 1ns/10ps
module pbf_spi_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      csn,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    csn  = 1'b1;
    mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // the host reaches the buffers through this port only; the bench drives demod_in and mod_req directly
  task automatic start();
    @(posedge clk);
    csn <= 1'b0;
    tick(8);
  endtask

  // a released data line shows the inverse of its last value, never a held copy
  task automatic stop();
    tick(8);
    csn  <= 1'b1;
    mosi <= ~mosi;
    tick(8);
  endtask

  // mode 0, msb first; 8 clk half period keeps margin over the 6 clk minimum
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      tick(8);
      sclk  <= 1'b1;
      rx[i] = miso;
      tick(8);
      sclk <= 1'b0;
    end
  endtask
endmodule

// file: test/pbf_fifo_pair_bench.sv
// self-checking bench for the packet byte fifo pair
`timescale 1ns/10ps
module pbf_fifo_pair_bench
  import pbf_pkg::*;
;
  localparam logic [2:0] RSTATE = 3'h5;
  logic                          clk = 1'b0;
  logic                          link_clk = 1'b1;
  logic                          resetn = 1'b0;
  logic                          sclk, csn, mosi, miso, miso_oe_n;
  logic                          sleep_req = 1'b0;
  logic [3:0]                    thr = 4'h0;
  pbf_gpo_src_t [GPO_PINS-1:0]   pin_src = '{SRC_RX_AVAIL, SRC_TX_THR, SRC_RX_THR};
  pbf_byte_t                     demod_in = '0;
  logic                          mod_req = 1'b0;
  logic                          rx_wr_ready, rx_ovf, tx_udf;
  pbf_byte_t                     mod_out;
  logic [CNT_W-1:0]              rx_cnt, tx_cnt;
  logic [GPO_PINS-1:0]           gpo;
  int                            fails = 0;
  int                            n_checks = 0;

  always #12.5 clk = ~clk;
  // 15 ns link period, offset so its edges never meet the 25 ns clock
  initial begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  pbf_fifo_pair #(.DEPTH(FIFO_DEPTH)) i_pbf_fifo_pair (
    .clk                      (clk),
    .resetn                   (resetn),
    .link_clk                 (link_clk),
    .spi_sclk                 (sclk),
    .spi_csn                  (csn),
    .spi_mosi                 (mosi),
    .spi_miso                 (miso),
    .spi_miso_oe_n            (miso_oe_n),
    .sleep_req                (sleep_req),
    .radio_state              (RSTATE),
    .fill_threshold_select    (thr),
    .output_pin_source_select (pin_src),
    .demod_in                 (demod_in),
    .rx_wr_ready              (rx_wr_ready),
    .mod_req                  (mod_req),
    .mod_out                  (mod_out),
    .rx_fill_count            (rx_cnt),
    .tx_fill_count            (tx_cnt),
    .rx_overflow              (rx_ovf),
    .tx_underflow             (tx_udf),
    .general_output_pin       (gpo)
  );

  pbf_spi_host i_pbf_spi_host (
    .clk  (clk),
    .sclk (sclk),
    .csn  (csn),
    .mosi (mosi),
    .miso (miso)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  // status byte as the host should see it during the header
  function automatic logic [7:0] st(input int c);
    return {1'b0, RSTATE, (c > 15) ? 4'hF : 4'(c)};
  endfunction

  // one spi frame: header, then n data bytes; read data is checked against base+i
  task automatic frame(input logic [7:0] hdr, input logic [7:0] est, input int n, input logic [7:0] base);
    logic [7:0] r;
    i_pbf_spi_host.start();
    chk(miso_oe_n, 1'b0, "miso enable in frame");
    i_pbf_spi_host.xfer(hdr, r);
    chk(r, est, "status byte");
    for (int i = 0; i < n; i++) begin
      i_pbf_spi_host.xfer(base + 8'(i), r);
      if (hdr[7])
        chk(r, base + 8'(i), "read byte");
    end
    i_pbf_spi_host.stop();
  endtask

  // back to back demodulator bytes, one per link cycle
  task automatic push(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge link_clk);
      demod_in <= '{valid: 1'b1, data: base + 8'(i)};
    end
    @(posedge link_clk);
    demod_in <= '0;
    wt(12);
  endtask

  task automatic pop(input logic [7:0] exp, input logic check);
    @(posedge link_clk);
    mod_req <= 1'b1;
    @(posedge link_clk);
    mod_req <= 1'b0;
    // valid stands for one link cycle only, so look right after the taking edge
    #1;
    if (check) begin
      chk(mod_out.valid, 1'b1, "mod valid");
      chk(mod_out.data, exp, "mod data");
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    wt(5);
    resetn <= 1'b1;
    wt(10);
    chk(miso_oe_n, 1'b1, "idle enable");
    chk(rx_cnt, 8'h00, "rx count reset");
    chk(tx_cnt, 8'h00, "tx count reset");
    chk(gpo, 8'h00, "pins reset");
    chk(rx_wr_ready, 1'b1, "rx ready");
    done("reset");

    push(32, 8'h40);
    chk(rx_cnt, 8'h20, "rx count 32");
    frame(8'h7F, st(0), 33, 8'h80);
    wt(10);
    chk(tx_cnt, 8'h21, "tx count 33");
    done("fill");

    for (int v = 0; v < 16; v++) begin
      @(posedge clk);
      thr <= 4'(v);
      wt(4);
      chk(gpo[0], 1'(32 >= 4 * (v + 1)), "rx threshold pin");
      chk(gpo[1], 1'(33 >= 61 - 4 * v), "tx threshold pin");
    end
    done("thresholds");

    frame(8'hBA, st(32), 1, 8'h20);
    frame(8'hBB, st(32), 1, 8'h21);
    frame(8'hB0, st(32), 1, 8'h00);
    done("status reads");

    @(posedge clk);
    thr <= 4'h7;
    frame(8'hFF, st(32), 31, 8'h40);
    wt(10);
    chk(rx_cnt, 8'h01, "rx count after drain");
    chk(gpo[0], 1'b0, "rx pin cleared");
    chk(gpo[2], 1'b1, "rx not empty pin");
    frame(8'hFF, st(1), 1, 8'h5F);
    wt(10);
    chk(gpo[2], 1'b0, "rx empty pin");
    done("rx drain");

    for (int i = 0; i < 33; i++)
      pop(8'h80 + 8'(i), 1'b1);
    chk(tx_udf, 1'b0, "no underflow yet");
    pop(8'h00, 1'b0);
    wt(10);
    chk(tx_udf, 1'b1, "tx underflow");
    chk(tx_cnt, 8'h00, "tx empty");
    chk(gpo[1], 1'b0, "tx pin cleared");
    @(posedge clk);
    pin_src[2] <= SRC_TX_FULL;
    wt(4);
    chk(gpo[2], 1'b0, "tx full pin");
    done("tx drain");

    push(64, 8'h00);
    chk(rx_cnt, 8'h40, "rx count 64");
    chk(rx_wr_ready, 1'b0, "rx full");
    @(posedge clk);
    thr <= 4'hF;
    wt(4);
    chk(gpo[0], 1'b1, "rx pin at 64");
    chk(rx_ovf, 1'b0, "no overflow yet");
    push(1, 8'hEE);
    chk(rx_ovf, 1'b1, "rx overflow");
    frame(8'hBA, st(64), 1, 8'hC0);
    done("overflow");

    @(posedge clk);
    sleep_req <= 1'b1;
    wt(6);
    chk(rx_cnt, 8'h00, "rx flushed");
    chk(tx_cnt, 8'h00, "tx flushed");
    @(posedge clk);
    sleep_req <= 1'b0;
    wt(10);
    chk(rx_ovf, 1'b0, "overflow cleared");
    chk(tx_udf, 1'b0, "underflow cleared");
    push(2, 8'h33);
    frame(8'hFF, st(2), 2, 8'h33);
    done("sleep");
    stop_test();
  end
endmodule
